//--- verilog/spi_fram_pkg.sv
// Shared constants and types for the serial memory slave front end
package spi_fram_pkg;
    // ==========================================================
    // Array geometry
    localparam int ADDR_W = 15;              // Byte address width
    localparam int BYTE_W = 8;               // Serial byte width
    localparam logic [2:0] LAST_BIT = 3'h7;  // Bit index of a byte's last bit
    localparam int FIFO_DEPTH = 16;          // Write buffer depth in words

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_SET_WEL = 8'h06;
    localparam logic [7:0] OP_CLR_WEL = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // ==========================================================
    // Status register layout
    localparam int SR_PPE_BIT = 7;           // protect_pin_enable_bit
    localparam int SR_WEL_BIT = 1;           // Write enable latch
    localparam logic [7:0] SR_RESET = 8'h00; // Value after reset
    localparam logic [7:0] SR_WR_MASK = 8'h8c; // Bits a status write may change

    // ==========================================================
    // Frame states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DUMMY,
        ST_WDATA,
        ST_RDATA,
        ST_SR_WRITE,
        ST_SR_READ,
        ST_IGNORE
    } frame_state_t;

    // Kind of array access in progress
    typedef enum logic [1:0] {
        ACC_READ,
        ACC_FAST,
        ACC_WRITE
    } access_t;
endpackage

//--- verilog/spi_sync.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module spi_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    // ==========================================================
    // Synchroniser stages
    logic [WIDTH-1:0] meta; // First stage, read only by the second

    // Both stages load the idle pin levels at reset
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            meta <= RESET_VAL;
            q_o <= RESET_VAL;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

//--- verilog/spi_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module spi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    // ==========================================================
    // Elaboration check
    localparam int PTR_W = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("spi_fifo depth must be a power of two of at least 2");
    end

    // ==========================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH]; // Word storage
    logic [PTR_W:0] wr_ptr;        // Write pointer with wrap bit
    logic [PTR_W:0] rd_ptr;        // Read pointer with wrap bit
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready_o = !(wr_ptr[PTR_W] != rd_ptr[PTR_W] &&
                          wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o = mem[rd_ptr[PTR_W-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Write side
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
        end else if (push) begin
            mem[wr_ptr[PTR_W-1:0]] <= in_data_i;
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // Read side
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

//--- verilog/spi_fram_slave.sv
// Serial peripheral slave front end of a byte-wide nonvolatile memory
`timescale 1ns/100ps
module spi_fram_slave #(
    parameter int ADDR_W = spi_fram_pkg::ADDR_W,
    parameter int FIFO_DEPTH = spi_fram_pkg::FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic sck_i,                  // Serial clock pin
    input wire logic cs_n_i,                 // Select pin, active low
    input wire logic si_i,                   // Serial data in pin
    input wire logic hold_n_i,               // Suspend pin, active low
    input wire logic wp_n_i,                 // Write protect pin, active low
    output logic so_o,                       // Serial data out level
    output logic so_oe_n_o,                  // Output enable, low drives
    output logic mem_rd_o,                   // Array read strobe
    output logic [ADDR_W-1:0] mem_rd_addr_o, // Array read address
    input wire logic [7:0] mem_rdata_i,      // Read data, one cycle later
    output logic mem_wr_valid_o,             // Buffered write available
    input wire logic mem_wr_ready_i,         // Array takes the write
    output logic [ADDR_W-1:0] mem_wr_addr_o, // Buffered write address
    output logic [7:0] mem_wr_data_o,        // Buffered write data
    output logic [7:0] status_o,             // Status register contents
    output logic mode3_o,                    // Frame runs in mode 3
    output logic wr_overrun_o                // Write byte lost this frame
);
    // ==========================================================
    // Elaboration check
    if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr
        $error("spi_fram_slave address width must lie in 9..16");
    end

    // ==========================================================
    // Pin synchronisation and edge detection
    logic sck_s, cs_s, si_s, hold_s, wp_s; // Synchronised pin levels
    logic sck_d;                           // Clock level last seen
    logic cs_d;                            // Select level last seen
    logic rise, fall, cs_fall, cs_rise;

    // Idle levels: clock low, select high, data low, suspend and protect high
    // Matches the clock history reset so no false edge follows reset
    localparam logic [4:0] PIN_IDLE = 5'h0b;

    spi_sync #(.WIDTH(5), .RESET_VAL(PIN_IDLE)) u_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .d_i({sck_i, cs_n_i, si_i, hold_n_i, wp_n_i}),
        .q_o({sck_s, cs_s, si_s, hold_s, wp_s})
    );

    // Edge history frozen while suspended so a net level change shows as an edge on resume
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else if (hold_s) begin
            sck_d <= sck_s;
            cs_d <= cs_s;
        end
    end

    spi_fram_pkg::frame_state_t state;
    spi_fram_pkg::access_t access;
    // Clock edges count only inside an active, unsuspended frame
    assign rise = hold_s && !cs_s && sck_s && !sck_d && state != spi_fram_pkg::ST_IDLE;
    assign fall = hold_s && !cs_s && !sck_s && sck_d && state != spi_fram_pkg::ST_IDLE;
    assign cs_fall = hold_s && !cs_s && cs_d;
    assign cs_rise = hold_s && cs_s && !cs_d;

    // ==========================================================
    // Input shifter
    logic [7:0] shift_in;    // Bits gathered so far
    logic [2:0] bit_cnt;     // Bit position within the byte
    logic [7:0] next_byte;   // Byte including the bit sampled now
    logic byte_done;         // Last bit of a byte sampled
    logic [ADDR_W-1:0] addr; // Array address pointer

    assign next_byte = {shift_in[6:0], si_s};
    assign byte_done = rise && bit_cnt == spi_fram_pkg::LAST_BIT;

    // Sample on rising edges only; a stopped clock simply waits
    always_ff @(posedge core_clk_i) begin
        if (srst_i || (hold_s && cs_s)) begin
            shift_in <= '0;
            bit_cnt <= '0;
        end else if (rise) begin
            shift_in <= next_byte;
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // Mode caught from the clock level when select falls
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mode3_o <= 1'b0;
        end else if (cs_fall) begin
            mode3_o <= sck_s;
        end
    end

    // ==========================================================
    // Frame state machine
    // Only the master's select starts a frame; nothing here initiates
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= spi_fram_pkg::ST_IDLE;
            access <= spi_fram_pkg::ACC_READ;
        end else if (!hold_s) begin
            state <= state;
        end else if (cs_s) begin
            state <= spi_fram_pkg::ST_IDLE;
        end else if (cs_fall) begin
            state <= spi_fram_pkg::ST_OPCODE;
        end else if (byte_done) begin
            case (state)
                spi_fram_pkg::ST_OPCODE: begin
                    case (next_byte)
                        spi_fram_pkg::OP_RD_STAT: state <= spi_fram_pkg::ST_SR_READ;
                        spi_fram_pkg::OP_WR_STAT: state <= spi_fram_pkg::ST_SR_WRITE;
                        spi_fram_pkg::OP_READ: begin
                            state <= spi_fram_pkg::ST_ADDR_HI;
                            access <= spi_fram_pkg::ACC_READ;
                        end
                        spi_fram_pkg::OP_FAST_READ: begin
                            state <= spi_fram_pkg::ST_ADDR_HI;
                            access <= spi_fram_pkg::ACC_FAST;
                        end
                        spi_fram_pkg::OP_WRITE: begin
                            state <= spi_fram_pkg::ST_ADDR_HI;
                            access <= spi_fram_pkg::ACC_WRITE;
                        end
                        // Latch ops and unknown codes ignore the rest
                        default: state <= spi_fram_pkg::ST_IGNORE;
                    endcase
                end
                spi_fram_pkg::ST_ADDR_HI: state <= spi_fram_pkg::ST_ADDR_LO;
                spi_fram_pkg::ST_ADDR_LO: begin
                    case (access)
                        spi_fram_pkg::ACC_WRITE: state <= spi_fram_pkg::ST_WDATA;
                        spi_fram_pkg::ACC_FAST: state <= spi_fram_pkg::ST_DUMMY;
                        default: state <= spi_fram_pkg::ST_RDATA;
                    endcase
                end
                spi_fram_pkg::ST_DUMMY: state <= spi_fram_pkg::ST_RDATA;
                default: state <= state;
            endcase
        end
    end

    // ==========================================================
    // Address pointer
    // Top address bit is dropped; the pointer wraps inside the array
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            addr <= '0;
        end else if (byte_done) begin
            if (state == spi_fram_pkg::ST_ADDR_HI) begin
                addr[ADDR_W-1:8] <= next_byte[ADDR_W-9:0];
            end else if (state == spi_fram_pkg::ST_ADDR_LO) begin
                addr[7:0] <= next_byte;
            end else if (state == spi_fram_pkg::ST_WDATA || state == spi_fram_pkg::ST_RDATA) begin
                addr <= addr + 1'b1;
            end
        end
    end

    // ==========================================================
    // Status register and write enable latch
    logic wel_clr_pend; // Latch clears when select rises
    logic sr_commit;    // Status write byte complete
    logic sr_blocked;   // Protect pin vetoes status writes

    assign sr_commit = byte_done && state == spi_fram_pkg::ST_SR_WRITE;
    assign sr_blocked = status_o[spi_fram_pkg::SR_PPE_BIT] && !wp_s;

    // Latch set by its opcode, cleared after a write-type frame ends
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            status_o <= spi_fram_pkg::SR_RESET;
            wel_clr_pend <= 1'b0;
        end else begin
            if (cs_rise) begin
                wel_clr_pend <= 1'b0;
                if (wel_clr_pend) begin
                    status_o[spi_fram_pkg::SR_WEL_BIT] <= 1'b0;
                end
            end else if (byte_done && state == spi_fram_pkg::ST_OPCODE) begin
                if (next_byte == spi_fram_pkg::OP_SET_WEL) begin
                    status_o[spi_fram_pkg::SR_WEL_BIT] <= 1'b1;
                end
                if (next_byte == spi_fram_pkg::OP_CLR_WEL ||
                    next_byte == spi_fram_pkg::OP_WR_STAT ||
                    next_byte == spi_fram_pkg::OP_WRITE) begin
                    wel_clr_pend <= 1'b1;
                end
            end else if (sr_commit && status_o[spi_fram_pkg::SR_WEL_BIT] && !sr_blocked) begin
                status_o <= (status_o & ~spi_fram_pkg::SR_WR_MASK) |
                            (next_byte & spi_fram_pkg::SR_WR_MASK);
            end
        end
    end

    // ==========================================================
    // Write path through the buffer
    logic wr_pend;                     // Word waiting for buffer space
    logic [ADDR_W+7:0] wr_word;        // Address and data of that word
    logic fifo_in_ready;
    logic wr_byte;                     // Data byte completed and enabled

    assign wr_byte = byte_done && state == spi_fram_pkg::ST_WDATA &&
                     status_o[spi_fram_pkg::SR_WEL_BIT];

    // Holding stage absorbs a full buffer for up to one byte time
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_pend <= 1'b0;
            wr_word <= '0;
            wr_overrun_o <= 1'b0;
        end else begin
            if (cs_fall) begin
                wr_overrun_o <= 1'b0;
            end else if (wr_byte && wr_pend && !fifo_in_ready) begin
                wr_overrun_o <= 1'b1;
            end
            if (wr_byte && !(wr_pend && !fifo_in_ready)) begin
                wr_pend <= 1'b1;
                wr_word <= {addr, next_byte};
            end else if (fifo_in_ready) begin
                wr_pend <= 1'b0;
            end
        end
    end

    spi_fifo #(.WIDTH(ADDR_W + 8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .in_valid_i(wr_pend),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wr_word),
        .out_valid_o(mem_wr_valid_o),
        .out_ready_i(mem_wr_ready_i),
        .out_data_o({mem_wr_addr_o, mem_wr_data_o})
    );

    // ==========================================================
    // Read path
    logic rd_req;         // Fetch needed at the current pointer
    logic rd_load;        // Read data arrives this cycle
    logic [7:0] out_shift; // Bits still to send, MSB first

    // Fetch after the plain read address, the fast read dummy byte and each data byte
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_req <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_rd_addr_o <= '0;
            rd_load <= 1'b0;
        end else begin
            rd_req <= byte_done && (state == spi_fram_pkg::ST_RDATA ||
                      state == spi_fram_pkg::ST_DUMMY ||
                      (state == spi_fram_pkg::ST_ADDR_LO &&
                       access == spi_fram_pkg::ACC_READ));
            mem_rd_o <= rd_req;
            rd_load <= mem_rd_o;
            if (rd_req) begin
                mem_rd_addr_o <= addr;
            end
        end
    end

    // Output level changes only on falling edges or deselect; the shifter also loads read data or status
    always_ff @(posedge core_clk_i) begin
        if (srst_i || (hold_s && cs_s)) begin
            out_shift <= '0;
            so_o <= 1'b0;
        end else if (rd_load) begin
            out_shift <= mem_rdata_i;
        end else if (byte_done && (state == spi_fram_pkg::ST_SR_READ ||
                     (state == spi_fram_pkg::ST_OPCODE &&
                      next_byte == spi_fram_pkg::OP_RD_STAT))) begin
            out_shift <= status_o;
        end else if (fall) begin
            so_o <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
        end
    end

    // Driver enabled only while returning data and not suspended
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            so_oe_n_o <= 1'b1;
        end else begin
            so_oe_n_o <= !(hold_s && !cs_s && (state == spi_fram_pkg::ST_RDATA ||
                           state == spi_fram_pkg::ST_SR_READ));
        end
    end

    // ==========================================================
    // Assertions
    sequence s_sel_fall;
        cs_fall;
    endsequence

    sequence s_wr_byte;
        wr_byte && !wr_pend;
    endsequence

    property p_suspend_tristate;
        @(posedge core_clk_i) disable iff (srst_i) !hold_s |=> so_oe_n_o;
    endproperty
    a_suspend_tristate: assert property (p_suspend_tristate)
        else $error("output driven while suspended");

    property p_deselect_idle;
        @(posedge core_clk_i) disable iff (srst_i)
            (cs_s && hold_s) |=> (state == spi_fram_pkg::ST_IDLE) && so_oe_n_o;
    endproperty
    a_deselect_idle: assert property (p_deselect_idle)
        else $error("frame active while deselected");

    property p_status_protect;
        @(posedge core_clk_i) disable iff (srst_i)
            (sr_commit && status_o[spi_fram_pkg::SR_PPE_BIT] && !wp_s) |=> $stable(status_o);
    endproperty
    a_status_protect: assert property (p_status_protect)
        else $error("status written while pin protected");

    property p_sample_on_rise;
        @(posedge core_clk_i) disable iff (srst_i)
            (!rise && !cs_s) |=> $stable(shift_in) && $stable(bit_cnt);
    endproperty
    a_sample_on_rise: assert property (p_sample_on_rise)
        else $error("input shifted without rising edge");

    property p_suspend_freeze;
        @(posedge core_clk_i) disable iff (srst_i)
            !hold_s |=> $stable(state) && $stable(bit_cnt) && $stable(addr);
    endproperty
    a_suspend_freeze: assert property (p_suspend_freeze)
        else $error("state moved while suspended");

    property p_opcode_first;
        @(posedge core_clk_i) disable iff (srst_i)
            s_sel_fall |=> state == spi_fram_pkg::ST_OPCODE && bit_cnt == 3'h0;
    endproperty
    a_opcode_first: assert property (p_opcode_first)
        else $error("select fall did not open opcode phase");

    property p_mode_pick;
        @(posedge core_clk_i) disable iff (srst_i)
            s_sel_fall |=> mode3_o == $past(sck_s);
    endproperty
    a_mode_pick: assert property (p_mode_pick)
        else $error("mode not taken from clock level");

    property p_ignore_stays;
        @(posedge core_clk_i) disable iff (srst_i)
            (state == spi_fram_pkg::ST_IGNORE && !cs_s) |=>
                (state == spi_fram_pkg::ST_IGNORE) && so_oe_n_o;
    endproperty
    a_ignore_stays: assert property (p_ignore_stays)
        else $error("ignored frame left ignore state");

    property p_write_commit;
        @(posedge core_clk_i) disable iff (srst_i)
            s_wr_byte |=> wr_pend && wr_word[7:0] == $past(next_byte);
    endproperty
    a_write_commit: assert property (p_write_commit)
        else $error("written byte not queued");
endmodule

//--- testbench/spi_master_model.sv
// Bus master model driving clock, select, data and suspend pins
`timescale 1ns/100ps
module spi_master_model (
    input wire logic core_clk_i,
    input wire logic so_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o
);
    // ==========
    // Idle pins at time zero
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end
    // Half a link period is four core cycles (160 ns period)
    task automatic half(input int n);
        repeat (4 * n) @(negedge core_clk_i);
    endtask
    // Park clock at the mode level, then select
    task automatic start(input logic m3);
        sck_o = m3;
        half(1);
        cs_n_o = 1'b0;
        half(1);
    endtask
    // Clock back to idle before deselect; released data line flips
    task automatic stop(input logic m3);
        half(1);
        sck_o = m3;
        half(1);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        half(2);
    endtask
    // One byte; suspend before bit hb while clock keeps toggling
    task automatic xfer(input logic [7:0] tx, input int hb, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            half(1);
            if (i == hb) begin
                hold_n_o = 1'b0;
                half(1);
                repeat (2) begin
                    sck_o = 1'b1;
                    si_o = ~si_o;
                    half(1);
                    sck_o = 1'b0;
                    half(1);
                end
                si_o = tx[i];
                hold_n_o = 1'b1;
                half(1);
            end
            rx[i] = so_i;
            sck_o = 1'b1;
            half(1);
        end
    endtask
endmodule

//--- testbench/spi_fram_slave_test.sv
// Self-checking bench for the serial memory slave front end
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); end end
module spi_fram_slave_test;
    // ==========
    // Pins, array model and bench state
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic sck, cs_n, si, hold_n, so_o, so_oe_n_o;
    logic wp_n = 1'b1;
    logic mem_rd_o, mem_wr_valid_o, mode3_o, wr_overrun_o;
    logic mem_wr_ready_i = 1'b0;
    logic [7:0] mem_rdata_i = 8'h00;
    logic [7:0] mem_wr_data_o, status_o;
    logic [spi_fram_pkg::ADDR_W-1:0] mem_rd_addr_o, mem_wr_addr_o;
    logic [7:0] mem [0:32767];
    logic [7:0] rxq[$];
    logic [7:0] tx[$];
    logic [7:0] exp_q[$];
    logic [7:0] sr = 8'h00;       // Expected status
    logic [7:0] bad[4] = '{8'hc3, 8'hc2, 8'h5a, 8'h5b};
    logic [15:0] a;
    logic stall = 1'b1;           // Array refuses writes while set
    logic oe_seen;
    int miscompares, samples_checked, hdr;
    int seed = 97;
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    spi_master_model i_master (.core_clk_i(core_clk_i), .so_i(so_oe_n_o ? ~so_o : so_o),
        .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));
    spi_fram_slave i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .sck_i(sck),
        .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so_o),
        .so_oe_n_o(so_oe_n_o), .mem_rd_o(mem_rd_o), .mem_rd_addr_o(mem_rd_addr_o),
        .mem_rdata_i(mem_rdata_i), .mem_wr_valid_o(mem_wr_valid_o),
        .mem_wr_ready_i(mem_wr_ready_i), .mem_wr_addr_o(mem_wr_addr_o),
        .mem_wr_data_o(mem_wr_data_o), .status_o(status_o), .mode3_o(mode3_o),
        .wr_overrun_o(wr_overrun_o));
    // Array: data a cycle after the strobe, writes on handshake
    always @(posedge core_clk_i) begin
        if (mem_rd_o) mem_rdata_i <= mem[mem_rd_addr_o];
        if (mem_wr_valid_o && mem_wr_ready_i) mem[mem_wr_addr_o] <= mem_wr_data_o;
        if (!so_oe_n_o) oe_seen <= 1'b1;
    end
    // Random stalls keep the write buffer partly full
    always @(negedge core_clk_i) mem_wr_ready_i <= !stall && 1'($random(seed));
    // Status after a write attempt
    function automatic logic [7:0] exp_sr(input logic [7:0] cur, w, input logic wp);
        return (cur[7] && !wp) ? cur : (w & spi_fram_pkg::SR_WR_MASK);
    endfunction
    // One select cycle, bytes opcode first
    task automatic frame(input logic m3, input logic [7:0] b[$], input int hb);
        logic [7:0] r;
        rxq = {};
        oe_seen = 1'b0;
        i_master.start(m3);
        foreach (b[k]) begin
            i_master.xfer(b[k], hb - 8 * k, r);
            rxq.push_back(r);
        end
        `CHK(mode3_o, m3)
        i_master.stop(m3);
        `CHK(so_oe_n_o, 1'b1)
    endtask
    // Let the array take everything, bounded
    task automatic drain();
        stall = 1'b0;
        for (int i = 0; i < 99 && mem_wr_valid_o; i++) @(negedge core_clk_i);
        `CHK(mem_wr_valid_o, 1'b0)
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog, about four times the expected run
    initial begin
        repeat (40000) @(posedge core_clk_i);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(negedge core_clk_i);
        srst_i = 1'b0;
        `CHK(so_oe_n_o, 1'b1)
        `CHK(status_o, spi_fram_pkg::SR_RESET)
        // Status writes: taken, refused by the protect pin, taken
        for (int t = 0; t < 3; t++) begin
            wp_n = (t != 1);
            frame(1'b0, {spi_fram_pkg::OP_SET_WEL}, -1);
            frame(1'b1, {spi_fram_pkg::OP_WR_STAT, t ? 8'h04 : 8'h8c}, -1);
            sr = exp_sr(sr, t ? 8'h04 : 8'h8c, wp_n);
            frame(1'b0, {spi_fram_pkg::OP_RD_STAT, 8'h00}, -1);
            `CHK(rxq[1], sr)
            `CHK(oe_seen, 1'b1)
        end
        // Latch set alone survives select rise; clear opcode drops it
        frame(1'b1, {spi_fram_pkg::OP_SET_WEL}, -1);
        `CHK(status_o, sr | 8'h02)
        frame(1'b0, {spi_fram_pkg::OP_CLR_WEL}, -1);
        `CHK(status_o, sr)
        $display("test status done");
        // Writes then reads; top address bit set, first pass wraps
        for (int n = 0; n < 4; n++) begin
            a = n ? (16'($random(seed)) | 16'h8000) : 16'hfffe;
            exp_q = {};
            repeat (3 + n) exp_q.push_back(8'($random(seed)));
            stall = n[0];
            frame(1'b0, {spi_fram_pkg::OP_SET_WEL}, -1);
            frame(n[0], {spi_fram_pkg::OP_WRITE, a[15:8], a[7:0], exp_q}, 30 + n);
            `CHK(oe_seen, 1'b0)
            `CHK(wr_overrun_o, 1'b0)
            drain();
            `CHK(mem[a[14:0]], exp_q[0])
            hdr = n[1] ? 4 : 3;
            tx = {n[1] ? spi_fram_pkg::OP_FAST_READ : spi_fram_pkg::OP_READ, a[15:8], a[7:0], 8'h00};
            frame(!n[0], {tx[0:hdr-1], exp_q}, 33 + n);
            foreach (exp_q[k]) `CHK(rxq[hdr + k], exp_q[k])
        end
        $display("test array done");
        // Reserved codes: rest ignored, output stays off
        foreach (bad[j]) begin
            frame(j[0], {bad[j], spi_fram_pkg::OP_READ, 8'h00, 8'h00}, -1);
            `CHK(oe_seen, 1'b0)
        end
        $display("test reserved done");
        // Buffer fills while the array stalls; excess bytes are lost
        stall = 1'b1;
        frame(1'b0, {spi_fram_pkg::OP_SET_WEL}, -1);
        frame(1'b1, {spi_fram_pkg::OP_WRITE, 8'h00, 8'h00, exp_q, exp_q, exp_q, exp_q}, -1);
        `CHK(mem_wr_valid_o, 1'b1)
        `CHK(wr_overrun_o, 1'b1)
        drain();
        $display("test overrun done");
        tally_and_finish();
    end
endmodule
